// ---- core/hub_config_defines.vh ----
// Purpose: Constants for the hub configuration strap register
// Assumes: 8-bit register, low three bits handled here
// Notes:   Included by the register block
`ifndef HUB_CONFIG_DEFINES_VH
`define HUB_CONFIG_DEFINES_VH
`define CFG_RSVD_BIT      0
`define CFG_OVR_BIT       1
`define CFG_PWRSEL_BIT    2
`define CFG_UPPER_MASK    8'hf8
`define TIMEOUT_ZERO      8'h00
`define TIMEOUT_MAX       8'hff
`define MODE_STRAP        2'h0
`define MODE_I2C          2'h1
`define MODE_SMBUS        2'h2
`endif

// ---- core/strap_sync.v ----
// Purpose: Two-flop synchroniser for strap pins and mode inputs
// Assumes: Inputs come from pins outside the ref_clk domain
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module strap_sync #(
    parameter WIDTH = 2
) (
    // Clock and reset
    input  wire             ref_clk,
    input  wire             reset_n,
    // Data
    input  wire [WIDTH-1:0] asyncIn,
    output reg  [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1_reg;

    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1_reg <= {WIDTH{1'b0}};
            syncOut    <= {WIDTH{1'b0}};
        end
        else
        begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end
endmodule

// ---- core/hub_config_strap_bits.v ----
// Purpose: Low three bits of the hub device configuration register
// Assumes: Strap pins and config mode are async pins; loads and writes are ref_clk pulses
// Notes:   Straps are captured on the third edge after reset release
// Summary of operation
// - Override bit set substitutes device value for software U1/U2 timeouts.
// - Override active: nonzero timeout 1..FF becomes FF.
// - Override active: zero timeout stays zero.
// - Override bit defaults from serial clock strap pin at reset release.
// - In I2C mode the EEPROM load replaces strapped defaults.
// - In SMBus mode host writes replace strapped defaults.
// - Power select bit defaults from power management strap pin.
// - Power select strap captured when reset is deasserted.
// - Select 0: power switching and overcurrent both supported.
// - Select 1, bus-powered: switching yes, overcurrent no.
// - Select 1, self-powered: overcurrent yes, switching no.
// - Bit 0 reserved, reads zero, ignores writes.
`timescale 1ns/1ps
`include "hub_config_defines.vh"
module hub_config_strap_bits #(
    parameter PORTS = 4
) (
    // Clock and reset
    input  wire               ref_clk,
    input  wire               reset_n,
    // Strap pins and mode
    input  wire               serial_clock_strap_pin,
    input  wire               power_mgmt_strap_pin,
    input  wire [1:0]         configMode,
    input  wire               selfPowered,
    // EEPROM load
    input  wire               eepromLoad,
    input  wire [7:0]         eepromData,
    // SMBus host access
    input  wire               hostWrite,
    input  wire [7:0]         hostWriteData,
    output wire [7:0]         readData,
    // Timeouts
    input  wire [8*PORTS-1:0] swU1Timeout,
    input  wire [8*PORTS-1:0] swU2Timeout,
    output reg  [8*PORTS-1:0] u1Timeout,
    output reg  [8*PORTS-1:0] u2Timeout,
    // Power feature status
    output wire               link_idle_timeout_override,
    output wire               power_feature_select_n,
    output reg                powerSwitchSupported,
    output reg                overcurrentSupported
);
    wire [3:0] syncPins;
    reg        overrideBit_reg;
    reg        overrideBit_next;
    reg        powerSel_reg;
    reg        powerSel_next;
    reg  [1:0] startState_reg;
    reg  [1:0] startState_next;
    wire       strapCapture;
    wire       eepromTake;
    wire       hostTake;
    wire       ovrSync;
    wire       pwrSync;
    wire [1:0] modeSync;
    genvar     i;

    // Start-up sequence after reset release
    localparam [1:0] ST_FILL1   = 2'h0;
    localparam [1:0] ST_FILL2   = 2'h1;
    localparam [1:0] ST_CAPTURE = 2'h2;
    localparam [1:0] ST_RUN     = 2'h3;

    strap_sync #(
        .WIDTH(4)
    ) uSync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .asyncIn ({configMode, power_mgmt_strap_pin, serial_clock_strap_pin}),
        .syncOut (syncPins)
    );

    assign ovrSync  = syncPins[0];
    assign pwrSync  = syncPins[1];
    assign modeSync = syncPins[3:2];

    function [7:0] limitTimeout;
        input       ovr;
        input [7:0] swVal;
        begin
            if (ovr)
                limitTimeout = (swVal == `TIMEOUT_ZERO) ? `TIMEOUT_ZERO : `TIMEOUT_MAX;
            else
                limitTimeout = swVal;
        end
    endfunction

    // Config mode decode, shared by the load and write qualifiers
    function modeIs;
        input [1:0] mode;
        input [1:0] want;
        begin
            modeIs = (mode == want);
        end
    endfunction

    // Support flags as {power switching, overcurrent}
    function [1:0] supportFlags;
        input sel;
        input selfPwr;
        begin
            case ({sel, selfPwr})
                2'b00:   supportFlags = 2'b11;
                2'b01:   supportFlags = 2'b11;
                2'b10:   supportFlags = 2'b10;
                2'b11:   supportFlags = 2'b01;
                default: supportFlags = 2'b00;
            endcase
        end
    endfunction

    // Synchroniser needs two edges to fill before the straps can be trusted
    always @*
    begin
        case (startState_reg)
            ST_FILL1:   startState_next = ST_FILL2;
            ST_FILL2:   startState_next = ST_CAPTURE;
            ST_CAPTURE: startState_next = ST_RUN;
            ST_RUN:     startState_next = ST_RUN;
            default:    startState_next = ST_RUN;
        endcase
    end

    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            startState_reg <= ST_FILL1;
        else
            startState_reg <= startState_next;
    end

    assign strapCapture = (startState_reg == ST_CAPTURE);

    // A strobe in the wrong mode is dropped silently
    assign eepromTake = eepromLoad && modeIs(modeSync, `MODE_I2C);
    assign hostTake   = hostWrite && modeIs(modeSync, `MODE_SMBUS);

    always @*
    begin
        overrideBit_next = overrideBit_reg;
        powerSel_next    = powerSel_reg;
        if (strapCapture)
        begin
            overrideBit_next = ovrSync;
            powerSel_next    = pwrSync;
        end
        else if (eepromTake)
        begin
            overrideBit_next = eepromData[`CFG_OVR_BIT];
            powerSel_next    = eepromData[`CFG_PWRSEL_BIT];
        end
        else if (hostTake)
        begin
            overrideBit_next = hostWriteData[`CFG_OVR_BIT];
            powerSel_next    = hostWriteData[`CFG_PWRSEL_BIT];
        end
    end

    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            overrideBit_reg <= 1'b0;
            powerSel_reg    <= 1'b0;
        end
        else
        begin
            overrideBit_reg <= overrideBit_next;
            powerSel_reg    <= powerSel_next;
        end
    end

    // Upper bits belong to other fields and read as zero here
    assign readData = {5'h00, powerSel_reg, overrideBit_reg, 1'b0};
    assign link_idle_timeout_override = overrideBit_reg;
    assign power_feature_select_n     = powerSel_reg;

    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            powerSwitchSupported <= 1'b0;
            overcurrentSupported <= 1'b0;
        end
        else
        begin
            {powerSwitchSupported, overcurrentSupported} <= supportFlags(powerSel_reg, selfPowered);
        end
    end

    generate
        for (i = 0; i < PORTS; i = i + 1)
        begin : gPort
            // U1 lane of this port
            always @(posedge ref_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    u1Timeout[8*i+7:8*i] <= 8'h00;
                end
                else
                begin
                    u1Timeout[8*i+7:8*i] <= limitTimeout(overrideBit_reg, swU1Timeout[8*i+7:8*i]);
                end
            end

            // U2 lane of this port
            always @(posedge ref_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    u2Timeout[8*i+7:8*i] <= 8'h00;
                end
                else
                begin
                    u2Timeout[8*i+7:8*i] <= limitTimeout(overrideBit_reg, swU2Timeout[8*i+7:8*i]);
                end
            end
        end
    endgenerate
endmodule

// ---- verification/hub_config_monitor.sv ----
// Purpose: Port checker for hub_config_strap_bits
// Assumes: Port 0 timeout lanes stand for all lanes
// Notes:   Mode must be steady three edges before a write counts
`timescale 1ns/1ps
`include "hub_config_defines.vh"
module hub_config_monitor #(parameter PORTS = 4) (
    // Clock, reset and pins
    input ref_clk, reset_n, serial_clock_strap_pin, power_mgmt_strap_pin, selfPowered, eepromLoad, hostWrite,
    input [1:0] configMode,
    input [7:0] eepromData, hostWriteData, readData,
    // Timeouts and status
    input [8*PORTS-1:0] swU1Timeout, swU2Timeout, u1Timeout, u2Timeout,
    input link_idle_timeout_override, power_feature_select_n, powerSwitchSupported, overcurrentSupported
);
    wire       ovr = link_idle_timeout_override;
    wire       sel = power_feature_select_n;
    reg  [2:0] age_reg;
    always @(posedge ref_clk or negedge reset_n)
        if (!reset_n) age_reg <= 3'h0;
        else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    property p_ovrMax; ovr && swU1Timeout[7:0] != 8'h00 |=> u1Timeout[7:0] == 8'hff; endproperty
    a_ovrMax: assert property (p_ovrMax) else $error("override max wrong");
    property p_ovrZero; ovr && swU2Timeout[7:0] == 8'h00 |=> u2Timeout[7:0] == 8'h00; endproperty
    a_ovrZero: assert property (p_ovrZero) else $error("override zero wrong");
    property p_pass; !ovr |=> u1Timeout == $past(swU1Timeout); endproperty
    a_pass: assert property (p_pass) else $error("timeout passthrough wrong");
    property p_rsvd; readData[0] == 1'b0 && readData[7:3] == 5'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    property p_strap;
        $rose(reset_n) |-> ##3 readData[2:1] == {$past(power_mgmt_strap_pin, 3), $past(serial_clock_strap_pin, 3)};
    endproperty
    a_strap: assert property (p_strap) else $error("strap capture wrong");
    property p_host; hostWrite && !eepromLoad && age_reg > 3'h2 && configMode == `MODE_SMBUS
        && $past(configMode, 3) == `MODE_SMBUS |=> readData[2:1] == $past(hostWriteData[2:1]); endproperty
    a_host: assert property (p_host) else $error("host write lost");
    property p_eeprom; eepromLoad && age_reg > 3'h2 && configMode == `MODE_I2C
        && $past(configMode, 3) == `MODE_I2C |=> {sel, ovr} == $past(eepromData[2:1]); endproperty
    a_eeprom: assert property (p_eeprom) else $error("eeprom load lost");
    property p_sel0; !sel |=> powerSwitchSupported && overcurrentSupported; endproperty
    a_sel0: assert property (p_sel0) else $error("full support wrong");
    property p_sel1;
        sel |=> powerSwitchSupported != $past(selfPowered) && overcurrentSupported == $past(selfPowered);
    endproperty
    a_sel1: assert property (p_sel1) else $error("partial support wrong");
    c_host: cover property (hostWrite && configMode == `MODE_SMBUS);
    c_eeprom: cover property (eepromLoad && configMode == `MODE_I2C);
    c_self: cover property (sel && selfPowered && ovr);
endmodule
bind hub_config_strap_bits hub_config_monitor #(.PORTS(PORTS)) u_mon (.*);

// ---- verification/config_source.sv ----
// Purpose: SMBus host or EEPROM loader model
// Assumes: One byte per access, one-cycle strobe
// Notes:   Idle data lines show the inverse of the last byte
`timescale 1ns/1ps
module config_source (
    // Clock
    input            ref_clk,
    // Strobes and data
    output reg       eepromLoad, hostWrite,
    output reg [7:0] eepromData, hostWriteData
);
    initial {eepromLoad, hostWrite, eepromData, hostWriteData} = 18'h0;
    task put(input ee, input [7:0] d);
    begin
        @(posedge ref_clk) #5;
        {eepromLoad, hostWrite, eepromData, hostWriteData} = {ee, !ee, d, d};
        @(posedge ref_clk) #5;
        {eepromLoad, hostWrite, eepromData, hostWriteData} = {2'h0, ~d, ~d};
    end
    endtask
endmodule

// ---- verification/tb.sv ----
// Purpose: Self-checking bench for hub_config_strap_bits
// Assumes: One timeout lane, inputs driven 5 ns after the edge
// Notes:   Wrong-mode strobes follow each write and must be ignored
`timescale 1ns/1ps
`include "hub_config_defines.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    reg        ref_clk = 0, reset_n = 0, serial_clock_strap_pin = 1, power_mgmt_strap_pin = 0, selfPowered = 0;
    reg  [1:0] configMode = `MODE_SMBUS;
    reg  [7:0] swU1Timeout = 0, swU2Timeout = 0, r, regExp;
    reg [31:0] seed = 14446;
    wire [7:0] readData, u1Timeout, u2Timeout, eepromData, hostWriteData;
    wire       eepromLoad, hostWrite, link_idle_timeout_override, power_feature_select_n;
    wire       powerSwitchSupported, overcurrentSupported;
    integer    tests_run = 0, n_fail = 0, i;
    always #25 ref_clk = ~ref_clk;
    config_source u_src (.*);
    hub_config_strap_bits #(.PORTS(1)) u_dut (.*);
    function [7:0] rnd;
    begin
        seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5; rnd = seed[7:0];
    end
    endfunction
    function [7:0] expT(input o, input [7:0] v);
        expT = o ? (v != 8'h00 ? 8'hff : 8'h00) : v;
    endfunction
    task cyc(input integer n); repeat (n) @(posedge ref_clk); #5; endtask
    task end_of_test;
    begin
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        cyc(2);
        reset_n = 1;
        cyc(4);
        `CHK(readData, 8'h02)
        `CHK({power_feature_select_n, link_idle_timeout_override}, 2'h1)
        $display("strap test done");
        for (i = 0; i < 40; i++)
        begin
            r = rnd();
            if (i == 20)
            begin
                configMode = `MODE_I2C;
                cyc(3);
            end
            u_src.put(i >= 20, r);
            regExp = r & 8'h06;
            `CHK(readData, regExp)
            `CHK({power_feature_select_n, link_idle_timeout_override}, regExp[2:1])
            u_src.put(i < 20, ~r);
            `CHK(readData, regExp)
            swU1Timeout = (i % 3 == 0) ? 8'h00 : r + 8'h01;
            swU2Timeout = (i % 3 == 1) ? 8'h01 : (i % 3 == 2 ? 8'hff : rnd());
            selfPowered = r[7];
            cyc(1);
            `CHK(u1Timeout, expT(regExp[1], swU1Timeout))
            `CHK(u2Timeout, expT(regExp[1], swU2Timeout))
            `CHK({powerSwitchSupported, overcurrentSupported}, regExp[2] ? {!r[7], r[7]} : 2'h3)
        end
        $display("write and timeout test done");
        reset_n = 0;
        {serial_clock_strap_pin, power_mgmt_strap_pin} = 2'h1;
        cyc(2);
        `CHK(readData, 8'h00)
        reset_n = 1;
        cyc(4);
        `CHK(readData, 8'h04)
        $display("second reset test done");
        end_of_test;
    end
endmodule
